/* hdl/rcd_pkg.sv */
// constants and types for the 16-bit risc core
// assumes a single clock domain and one shared memory/peripheral bus
package rcd_pkg;

  // ----------------------------------------------------------------
  // start-up and power state
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] SLEEP_FLAGS = 16'h00F0;
  localparam int HALT_BIT = 4;

  // ----------------------------------------------------------------
  // register file roles and status flag positions
  // ----------------------------------------------------------------
  localparam logic [3:0] R_PC = 4'h0;
  localparam logic [3:0] R_STACK = 4'h1;
  localparam logic [3:0] R_STATUS = 4'h2;
  localparam logic [3:0] R_CG = 4'h3;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 8;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_MOV = 4'h4;
  localparam logic [3:0] OP_ADD = 4'h5;
  localparam logic [3:0] OP_ADDC = 4'h6;
  localparam logic [3:0] OP_SUBC = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_CMP = 4'h9;
  localparam logic [3:0] OP_DADD = 4'hA;
  localparam logic [3:0] OP_BIT = 4'hB;
  localparam logic [3:0] OP_BIC = 4'hC;
  localparam logic [3:0] OP_BIS = 4'hD;
  localparam logic [3:0] OP_XOR = 4'hE;
  localparam logic [3:0] OP_AND = 4'hF;
  localparam logic [2:0] SOP_RRC = 3'h0;
  localparam logic [2:0] SOP_SWPB = 3'h1;
  localparam logic [2:0] SOP_RRA = 3'h2;
  localparam logic [2:0] SOP_SXT = 3'h3;
  localparam logic [2:0] SOP_PUSH = 3'h4;
  localparam logic [2:0] SOP_CALL = 3'h5;

  typedef enum logic [3:0] {S_VEC, S_FETCH, S_DEC, S_SEXT, S_SVAL, S_DEXT, S_DVAL, S_EXEC,
    S_SLEEP} rcd_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic re;
    logic we;
    logic byte_en;
  } rcd_bus_type;

  typedef struct packed {
    rcd_state_type state;
    logic [15:0][15:0] regs;
    logic [15:0] ir;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] ea;
    rcd_bus_type bus;
  } rcd_core_type;

endpackage

/* hdl/rcd_core.sv */
// 16-bit risc core: fetch, operand resolution and execution
// assumes memory answers combinationally in the cycle its read strobe is high
// Operation
// - sixteen 16-bit registers; operands are copied into src and dst before execution.
// - R0 program counter, R1 stack pointer, R2 status, R3 constant generator.
// - registers four to fifteen are general purpose for any operand.
// - register to register operation takes three clock cycles: fetch, decode, execute.
// - operations act on registers; seven source modes, four destination modes.
// - dual-operand, single-operand and relative jump formats are decoded.
// - each instruction except a jump selects word or byte data.
// - call pushes program counter to stack top, then loads it from operand.
// - peripherals reached as plain operands over address, data and control bus.
// - start from reset vector word; all ones there means deepest sleep.
`timescale 1ns/1ps
`default_nettype none
module rcd_core (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // memory and peripheral bus
  output var rcd_pkg::rcd_bus_type MEM_BUS,
  input wire logic [15:0] MEM_RDATA,
  // power state
  output logic DEEP_SLEEP
);

  rcd_pkg::rcd_core_type q, d;
  logic [15:0] ins, sval, cgv, bval, a, bb, x, res, wv;
  logic [16:0] sum, dsum;
  logic [3:0] op, sreg, dreg, breg;
  logic [2:0] sop;
  logic [1:0] as_m;
  logic is_jmp, is_one, is_two, bw, ad, cg, src_ok, taken, arith, cin;
  logic fl, cy, ov, zr, wr;

  function automatic logic [15:0] msk(input logic [15:0] v, input logic b);
    msk = b ? {8'h00, v[7:0]} : v;
  endfunction

  function automatic logic top(input logic [15:0] v, input logic b);
    top = b ? v[7] : v[15];
  endfunction

  function automatic logic [15:0] pick(input logic [15:0] w, input logic hi, input logic b);
    pick = !b ? w : (hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
  endfunction

  // decimal add, nibble by nibble; carry comes from bit 7 or bit 15
  function automatic logic [16:0] dec_add(input logic [15:0] p, input logic [15:0] r,
                                          input logic ci, input logic b);
    logic [4:0] t;
    logic c;
    logic cb;
    logic [15:0] o;
    c = ci;
    cb = 1'b0;
    o = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      t = {1'b0, p[4*i+:4]} + {1'b0, r[4*i+:4]} + {4'h0, c};
      if (t > 5'h09)
        t = t + 5'h06;
      o[4*i+:4] = t[3:0];
      c = t[4];
      if (i == 1)
        cb = c;
    end
    dec_add = {b ? cb : c, o};
  endfunction

  always_comb
  begin
    d = q;
    d.bus.re = 1'b0;
    d.bus.we = 1'b0;
    ins = (q.state == rcd_pkg::S_DEC) ? MEM_RDATA : q.ir;
    // --------------------------------------------------------------
    // field decode
    // --------------------------------------------------------------
    is_jmp = ins[15:13] == 3'b001;
    is_one = ins[15:10] == 6'b000100;
    is_two = ins[15:14] != 2'b00;
    op = ins[15:12];
    sop = ins[9:7];
    bw = ins[6] & !is_jmp;
    ad = ins[7] & is_two;
    as_m = ins[5:4];
    sreg = is_two ? ins[11:8] : ins[3:0];
    dreg = ins[3:0];
    // constant generator replaces R3 always and R2 in the two upper modes
    cg = (sreg == rcd_pkg::R_CG) || (sreg == rcd_pkg::R_STATUS && as_m[1]);
    if (sreg == rcd_pkg::R_CG)
      cgv = (as_m == 2'b11) ? 16'hFFFF : {14'h0000, as_m};
    else
      cgv = as_m[0] ? 16'h0008 : 16'h0004;
    // indexed base: R2 gives absolute, R0 gives the extension word address
    breg = (q.state == rcd_pkg::S_SEXT) ? sreg : dreg;
    if (breg == rcd_pkg::R_STATUS)
      bval = 16'h0000;
    else if (breg == rcd_pkg::R_PC)
      bval = q.ea;
    else
      bval = q.regs[breg];
    case (ins[12:10])
      3'h0: taken = !q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_Z];
      3'h1: taken = q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_Z];
      3'h2: taken = !q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C];
      3'h3: taken = q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C];
      3'h4: taken = q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_N];
      3'h5: taken = !(q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_N] ^ q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_V]);
      3'h6: taken = q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_N] ^ q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_V];
      default: taken = 1'b1;
    endcase
    // --------------------------------------------------------------
    // alu operands and shared adder
    // --------------------------------------------------------------
    a = msk(q.dst, bw);
    x = msk(q.src, bw);
    arith = (op == rcd_pkg::OP_ADD) || (op == rcd_pkg::OP_ADDC) || (op == rcd_pkg::OP_SUBC) ||
            (op == rcd_pkg::OP_SUB) || (op == rcd_pkg::OP_CMP);
    bb = (op == rcd_pkg::OP_SUBC || op == rcd_pkg::OP_SUB || op == rcd_pkg::OP_CMP) ? msk(~q.src, bw) : x;
    if (op == rcd_pkg::OP_ADD)
      cin = 1'b0;
    else if (op == rcd_pkg::OP_SUB || op == rcd_pkg::OP_CMP)
      cin = 1'b1;
    else
      cin = q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C];
    sum = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
    dsum = dec_add(a, x, q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C], bw);
    res = 16'h0000;
    zr = 1'b0;
    wv = 16'h0000;
    fl = 1'b0;
    cy = 1'b0;
    ov = 1'b0;
    wr = 1'b0;
    src_ok = 1'b0;
    sval = 16'h0000;
    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    case (q.state)
      rcd_pkg::S_VEC:
      begin
        if (MEM_RDATA == rcd_pkg::ERASED_WORD)
        begin
          d.regs[rcd_pkg::R_STATUS] = rcd_pkg::SLEEP_FLAGS;
          d.state = rcd_pkg::S_SLEEP;
        end
        else
        begin
          d.regs[rcd_pkg::R_PC] = MEM_RDATA;
          d.state = rcd_pkg::S_FETCH;
        end
      end
      rcd_pkg::S_FETCH:
      begin
        if (q.regs[rcd_pkg::R_STATUS][rcd_pkg::HALT_BIT])
          d.state = rcd_pkg::S_SLEEP;
        else
        begin
          d.bus.re = 1'b1;
          d.bus.byte_en = 1'b0;
          d.bus.addr = q.regs[rcd_pkg::R_PC];
          d.regs[rcd_pkg::R_PC] = q.regs[rcd_pkg::R_PC] + 16'h0002;
          d.state = rcd_pkg::S_DEC;
        end
      end
      rcd_pkg::S_DEC:
      begin
        d.ir = MEM_RDATA;
        d.state = rcd_pkg::S_FETCH;
        if (is_jmp)
        begin
          if (taken)
            d.regs[rcd_pkg::R_PC] = q.regs[rcd_pkg::R_PC] + {{5{ins[9]}}, ins[9:0], 1'b0};
        end
        else if (is_one || is_two)
        begin
          d.bus.byte_en = bw;
          if (cg || as_m == 2'b00)
          begin
            src_ok = 1'b1;
            sval = cg ? cgv : msk(q.regs[sreg], bw);
          end
          else if (as_m == 2'b01)
          begin
            d.bus.re = 1'b1;
            d.bus.addr = q.regs[rcd_pkg::R_PC];
            d.ea = q.regs[rcd_pkg::R_PC];
            d.regs[rcd_pkg::R_PC] = q.regs[rcd_pkg::R_PC] + 16'h0002;
            d.state = rcd_pkg::S_SEXT;
          end
          else
          begin
            // indirect, autoincrement and immediate (autoincrement of R0)
            d.bus.re = 1'b1;
            d.bus.addr = q.regs[sreg];
            d.ea = q.regs[sreg];
            if (as_m[0])
              d.regs[sreg] = q.regs[sreg] + ((bw && sreg != rcd_pkg::R_PC && sreg != rcd_pkg::R_STACK) ?
                             16'h0001 : 16'h0002);
            d.state = rcd_pkg::S_SVAL;
          end
        end
      end
      rcd_pkg::S_SEXT, rcd_pkg::S_DEXT:
      begin
        d.ea = MEM_RDATA + bval;
        d.bus.re = 1'b1;
        d.bus.byte_en = bw;
        d.bus.addr = MEM_RDATA + bval;
        d.state = (q.state == rcd_pkg::S_SEXT) ? rcd_pkg::S_SVAL : rcd_pkg::S_DVAL;
      end
      rcd_pkg::S_SVAL:
      begin
        src_ok = 1'b1;
        sval = pick(MEM_RDATA, q.bus.addr[0], bw);
      end
      rcd_pkg::S_DVAL:
      begin
        d.dst = pick(MEM_RDATA, q.bus.addr[0], bw);
        d.state = rcd_pkg::S_EXEC;
      end
      rcd_pkg::S_EXEC:
      begin
        d.state = rcd_pkg::S_FETCH;
        if (is_two)
        begin
          wr = (op != rcd_pkg::OP_CMP) && (op != rcd_pkg::OP_BIT);
          fl = (op != rcd_pkg::OP_MOV) && (op != rcd_pkg::OP_BIC) && (op != rcd_pkg::OP_BIS);
          case (op)
            rcd_pkg::OP_MOV: res = x;
            rcd_pkg::OP_DADD: res = dsum[15:0];
            rcd_pkg::OP_BIC: res = a & ~x;
            rcd_pkg::OP_BIS: res = a | x;
            rcd_pkg::OP_XOR: res = a ^ x;
            rcd_pkg::OP_BIT, rcd_pkg::OP_AND: res = a & x;
            default: res = sum[15:0];
          endcase
          zr = bw ? (res[7:0] == 8'h00) : (res == 16'h0000);
          if (arith)
          begin
            cy = bw ? sum[8] : sum[16];
            ov = (top(a, bw) == top(bb, bw)) && (top(res, bw) != top(a, bw));
          end
          else if (op == rcd_pkg::OP_DADD)
            cy = dsum[16];
          else
          begin
            cy = !zr;
            ov = (op == rcd_pkg::OP_XOR) && top(a, bw) && top(x, bw);
          end
        end
        else
        begin
          wr = sop < rcd_pkg::SOP_PUSH;
          fl = (sop != rcd_pkg::SOP_SWPB) && wr;
          cy = x[0];
          case (sop)
            rcd_pkg::SOP_RRC:
              res = bw ? {8'h00, q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C], x[7:1]} :
                    {q.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C], x[15:1]};
            rcd_pkg::SOP_RRA: res = bw ? {8'h00, x[7], x[7:1]} : {x[15], x[15:1]};
            rcd_pkg::SOP_SWPB: res = {q.src[7:0], q.src[15:8]};
            rcd_pkg::SOP_SXT: res = {{8{q.src[7]}}, q.src[7:0]};
            default: res = 16'h0000;
          endcase
          zr = bw ? (res[7:0] == 8'h00) : (res == 16'h0000);
          if (sop == rcd_pkg::SOP_SXT)
            cy = !zr;
          if (sop == rcd_pkg::SOP_PUSH || sop == rcd_pkg::SOP_CALL)
          begin
            // stack grows down; the pushed word lands on the new top_of_stack
            d.regs[rcd_pkg::R_STACK] = q.regs[rcd_pkg::R_STACK] - 16'h0002;
            d.bus.we = 1'b1;
            d.bus.byte_en = 1'b0;
            d.bus.addr = q.regs[rcd_pkg::R_STACK] - 16'h0002;
            d.bus.wdata = (sop == rcd_pkg::SOP_CALL) ? q.regs[rcd_pkg::R_PC] : q.src;
            if (sop == rcd_pkg::SOP_CALL)
              d.regs[rcd_pkg::R_PC] = q.src;
          end
        end
        if (fl)
        begin
          d.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_C] = cy;
          d.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_Z] = zr;
          d.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_N] = top(res, bw);
          d.regs[rcd_pkg::R_STATUS][rcd_pkg::FLAG_V] = ov;
        end
        // explicit write to the status register wins over the flag update
        wv = msk(res, bw);
        if (wr && (ad || (is_one && as_m != 2'b00)))
        begin
          d.bus.we = 1'b1;
          d.bus.byte_en = bw;
          d.bus.addr = q.ea;
          d.bus.wdata = bw ? {res[7:0], res[7:0]} : res;
        end
        else if (wr && (is_two ? dreg : sreg) != rcd_pkg::R_CG)
          d.regs[is_two ? dreg : sreg] = wv;
      end
      default: ;
    endcase
    if (src_ok)
    begin
      d.src = sval;
      if (ad)
      begin
        d.bus.re = 1'b1;
        d.bus.byte_en = bw;
        d.bus.addr = q.regs[rcd_pkg::R_PC];
        d.ea = q.regs[rcd_pkg::R_PC];
        d.regs[rcd_pkg::R_PC] = q.regs[rcd_pkg::R_PC] + 16'h0002;
        d.state = rcd_pkg::S_DEXT;
      end
      else
      begin
        d.dst = is_two ? q.regs[dreg] : sval;
        d.state = rcd_pkg::S_EXEC;
      end
    end
  end

  // register file lives in the state struct; R3 storage is never written
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      q <= '0;
      q.state <= rcd_pkg::S_VEC;
      q.bus.re <= 1'b1;
      q.bus.addr <= rcd_pkg::RESET_VEC;
    end
    else
      q <= d;
  end

  assign MEM_BUS = q.bus;
  assign DEEP_SLEEP = q.state == rcd_pkg::S_SLEEP;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  property p_vec_read;
    $past(SYS_RST) |-> MEM_BUS.re && MEM_BUS.addr == rcd_pkg::RESET_VEC;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("reset vector not read");

  property p_sleep;
    q.state == rcd_pkg::S_VEC && MEM_RDATA == rcd_pkg::ERASED_WORD |=> DEEP_SLEEP [*3];
  endproperty
  a_sleep: assert property (p_sleep) else $error("erased vector did not sleep");

  property p_fetch;
    q.state == rcd_pkg::S_FETCH && !q.regs[rcd_pkg::R_STATUS][rcd_pkg::HALT_BIT] |=>
      MEM_BUS.re && MEM_BUS.addr == $past(q.regs[rcd_pkg::R_PC]) &&
      q.regs[rcd_pkg::R_PC] == $past(q.regs[rcd_pkg::R_PC]) + 16'h0002;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not from program counter");

  property p_regreg;
    q.state == rcd_pkg::S_EXEC && is_two && !ad && op == rcd_pkg::OP_MOV && !bw && dreg > 4'h3 |=>
      q.state == rcd_pkg::S_FETCH && q.regs[$past(dreg)] == $past(q.src);
  endproperty
  a_regreg: assert property (p_regreg) else $error("register move not done in one cycle");

  property p_autoinc;
    q.state == rcd_pkg::S_DEC && !is_jmp && (is_one || is_two) && as_m == 2'b11 && !bw && sreg > 4'h3 |=>
      q.regs[$past(sreg)] == $past(q.regs[sreg]) + 16'h0002 && MEM_BUS.addr == $past(q.regs[sreg]);
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("autoincrement wrong");

  property p_call;
    q.state == rcd_pkg::S_EXEC && is_one && sop == rcd_pkg::SOP_CALL |=>
      MEM_BUS.we && MEM_BUS.wdata == $past(q.regs[rcd_pkg::R_PC]) &&
      MEM_BUS.addr == $past(q.regs[rcd_pkg::R_STACK]) - 16'h0002 && q.regs[rcd_pkg::R_PC] == $past(q.src);
  endproperty
  a_call: assert property (p_call) else $error("call push or jump wrong");

  property p_memdst;
    q.state == rcd_pkg::S_EXEC && ad && op != rcd_pkg::OP_CMP && op != rcd_pkg::OP_BIT |=>
      MEM_BUS.we && MEM_BUS.addr == $past(q.ea) ##1 MEM_BUS.re;
  endproperty
  a_memdst: assert property (p_memdst) else $error("memory destination not written");

  property p_byte;
    q.state == rcd_pkg::S_EXEC && is_two && !ad && bw && op == rcd_pkg::OP_ADD && dreg > 4'h3 |=>
      q.regs[$past(dreg)][15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte) else $error("byte result left high byte");

endmodule
`default_nettype wire

/* testbench/rcd_mem_model.sv */
// program memory and memory-mapped peripheral space seen by the core
// assumes one access per cycle and reads answered in the cycle the strobe is high
`timescale 1ns/1ps
`default_nettype none
module rcd_mem_model (
  // clock
  input wire logic clk,
  // core side
  input wire rcd_pkg::rcd_bus_type mem_bus,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_q;

  // ----------------------------------------------------------------
  // storage access
  // ----------------------------------------------------------------
  initial
  begin
    last_q = 16'h0000;
    for (int i = 0; i < 32768; i++)
    begin
      mem[i] = 16'h0000;
    end
  end

  // outside a read the lines show the inverse of the last word, so stale data cannot pass for valid
  assign rdata = mem_bus.re ? mem[mem_bus.addr[15:1]] : ~last_q;

  // plain always, so that the bench may preload words between runs
  always @(posedge clk)
  begin
    if (mem_bus.re)
    begin
      last_q <= rdata;
    end
    if (mem_bus.we && !mem_bus.byte_en)
    begin
      mem[mem_bus.addr[15:1]] <= mem_bus.wdata;
    end
    else if (mem_bus.we && mem_bus.addr[0])
    begin
      mem[mem_bus.addr[15:1]][15:8] <= mem_bus.wdata[15:8];
    end
    else if (mem_bus.we)
    begin
      mem[mem_bus.addr[15:1]][7:0] <= mem_bus.wdata[7:0];
    end
  end

  task automatic load(input logic [15:0] a, input logic [15:0] d);
    mem[a[15:1]] = d;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_rcd_core.sv */
// self-checking bench for the 16-bit risc core
// assumes the core and a zero-latency memory model share one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_rcd_core;
  logic CLK_SYS;
  logic SYS_RST;
  rcd_pkg::rcd_bus_type MEM_BUS;
  logic [15:0] MEM_RDATA;
  logic DEEP_SLEEP;
  int err_total;
  int tests_run;
  int cyc;
  int rd_count;
  int first_rd [int];

  rcd_core rcd_core_i (
    .CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST),
    .MEM_BUS(MEM_BUS),
    .MEM_RDATA(MEM_RDATA),
    .DEEP_SLEEP(DEEP_SLEEP)
  );

  rcd_mem_model rcd_mem_model_i (
    .clk(CLK_SYS),
    .mem_bus(MEM_BUS),
    .rdata(MEM_RDATA)
  );

  initial
  begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------------------------------
  // read log: first cycle of each address, kept for timing checks
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST === 1'b0 && MEM_BUS.re === 1'b1)
    begin
      rd_count = rd_count + 1;
      if (!first_rd.exists(int'(MEM_BUS.addr)))
      begin
        first_rd[int'(MEM_BUS.addr)] = cyc;
      end
    end
    cyc = cyc + 1;
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d, comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    tests_run++;
    if (got != exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] peek(input logic [15:0] a);
    return rcd_mem_model_i.mem[a[15:1]];
  endfunction

  // reset is released just after an edge; the following cycle is the vector read
  task automatic do_reset(input logic [15:0] vec);
    SYS_RST = 1'b1;
    rcd_mem_model_i.load(rcd_pkg::RESET_VEC, vec);
    repeat (8) @(posedge CLK_SYS);
    #1;
    first_rd.delete();
    rd_count = 0;
    SYS_RST = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sleep();
    do_reset(rcd_pkg::ERASED_WORD);
    @(posedge CLK_SYS);
    #1;
    chk1(DEEP_SLEEP, 1'b1, "sleep one cycle after erased vector");
    repeat (20) @(posedge CLK_SYS);
    #1;
    chk1(DEEP_SLEEP, 1'b1, "sleep held");
    chk_cnt(rd_count, 1, "reads while asleep");
  endtask

  // program: immediate, reg-reg, add, word and byte stores, autoincrement, constants, call
  // subroutine: indexed source, byte add to register, one skipped and one taken branch
  task automatic t_program();
    logic [15:0] prog [25];
    logic [15:0] sub [13];
    int n;
    prog = '{16'h4034, 16'h1234, 16'h4405, 16'h5405, 16'h4582, 16'h0200, 16'h44C2, 16'h0203,
      16'h4036, 16'h0300, 16'h4637, 16'h4638, 16'h4782, 16'h0204, 16'h4882, 16'h0206,
      16'h4329, 16'h5239, 16'h4982, 16'h020A, 16'h4031, 16'h0280, 16'h12B0, 16'hC040, 16'h3FFF};
    for (int i = 0; i < 25; i++)
    begin
      rcd_mem_model_i.load(16'hC000 + 16'(2 * i), prog[i]);
    end
    sub = '{16'h4582, 16'h0208, 16'h461A, 16'h0002, 16'h5A45, 16'h2001, 16'h2401, 16'h4335,
      16'h4582, 16'h020C, 16'h4A82, 16'h020E, 16'h3FFF};
    for (int i = 0; i < 13; i++)
    begin
      rcd_mem_model_i.load(16'hC040 + 16'(2 * i), sub[i]);
    end
    rcd_mem_model_i.load(16'h0200, 16'hFFFF);
    rcd_mem_model_i.load(16'h0202, 16'hAAAA);
    rcd_mem_model_i.load(16'h0300, 16'h5555);
    rcd_mem_model_i.load(16'h0302, 16'h6666);
    // low byte 98 plus 68 wraps to zero, so the equal branch must be taken
    rcd_mem_model_i.load(16'h0306, 16'h1298);
    rcd_mem_model_i.load(16'h020C, 16'hFFFF);
    do_reset(16'hC000);
    n = 0;
    while (!first_rd.exists(32'hC058) && n < 3000)
    begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      $display("Error at %0t: program never reached its final loop", $time);
      return;
    end
    repeat (10) @(posedge CLK_SYS);
    #1;
    chk_cnt(first_rd[32'hC000] - first_rd[32'hFFFE], 2, "first fetch after vector");
    chk_cnt(first_rd[32'hC006] - first_rd[32'hC004], 3, "reg-reg fetch spacing");
    chk16(peek(16'h0200), 16'h2468, "word store of sum");
    chk16(peek(16'h0202), 16'h34AA, "byte store to odd address");
    chk16(peek(16'h0204), 16'h5555, "first autoincrement read");
    chk16(peek(16'h0206), 16'h6666, "second autoincrement read");
    chk16(peek(16'h020A), 16'h000A, "constant generator sum");
    chk16(peek(16'h027E), 16'hC030, "return address on stack");
    chk16(peek(16'h0208), 16'h2468, "store inside subroutine");
    chk_cnt(int'(first_rd.exists(32'hC030)), 0, "fall-through after call");
    chk16(peek(16'h020E), 16'h1298, "indexed source read");
    chk16(peek(16'h020C), 16'h0000, "byte add result after branches");
    chk_cnt(int'(first_rd.exists(32'hC04C)), 1, "fall-through of untaken branch");
    chk_cnt(int'(first_rd.exists(32'hC04E)), 0, "word under taken branch");
    chk1(DEEP_SLEEP, 1'b0, "awake with valid vector");
  endtask

  // ----------------------------------------------------------------
  // main sequence: the second reset lands while the core is still asleep
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    rd_count = 0;
    SYS_RST = 1'b1;
    #1;
    t_sleep();
    t_program();
    close_out();
  end
endmodule
`default_nettype wire
